/* kod_detect.sv */
// Purpose: k-line protocol detector, fast init then 5 baud init
// Assumes: a byte link layer below does bit timing and wake-up pulses
// Notes: bytes arrive with a three byte header; eom marks message end
//
// Our own choices: register access over APB and the register offsets.

// Function
// - after a good 5 baud init the transport layer is picked from the key bytes.
// - key bytes 0x8F with 0xE9, 0x6B, 0x6D or 0xEF mean the keyword protocol.
// - key byte pairs 0x08,0x08 and 0x94,0x94 mean the slow-init protocol.
// - a unit that reported 0x94 may answer at once; answers count within 0 to 50 ms.
// - the response timeout is 25000 us for fast init and 0 for 5 baud init.
// - fast init sends a start request whose data is the byte 0x81.
// - in fast init 0xC1 is a positive answer and 0x7F 0x81 a negative one.
// - 5 baud init starts by sending address 0x33 at 5 baud.
// - after 5 baud init 0x01 0x00 is sent; 0x41 0x00 is positive, 0x7F 0x01 negative.
// - with the extra header option set, the source address from the third header byte is returned.
// - answers carry the undefined tag until the tag table is configured.
// - the format byte reads 0x48 for the slow-init and 0x80 for the keyword protocol.
// - keyword key bytes decode to header formats.
// - fast init is tried first and 5 baud init follows as fallback.
module kod_detect
	import kod_pkg::*;
#(
	parameter int FAST_TMO = FAST_TMO_US,
	parameter int WIN_TMO = P2_WIN_US,
	parameter int KEY_TMO = KEY_WAIT_US
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// byte link towards the k-line
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic tx_slow_o,
	output logic tx_wake_o,
	input wire logic tx_done_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_eom_i,
	// per response report
	output logic resp_valid_o,
	output logic [7:0] resp_src_o,
	output logic [15:0] resp_tag_o
);

	typedef enum logic [9:0] {
		ST_IDLE = 10'b00_0000_0001,
		ST_F_WAKE = 10'b00_0000_0010,
		ST_F_SEND = 10'b00_0000_0100,
		ST_F_RESP = 10'b00_0000_1000,
		ST_S_ADDR = 10'b00_0001_0000,
		ST_S_KEYS = 10'b00_0010_0000,
		ST_S_REQ = 10'b00_0100_0000,
		ST_S_RESP = 10'b00_1000_0000,
		ST_DONE = 10'b01_0000_0000,
		ST_FAIL = 10'b10_0000_0000
	} kod_state_e;

	kod_state_e state_q;
	logic [2:0] ctrl_q;
	logic start_q;
	logic [15:0] tag_q;
	kod_keys_s keys_q;
	kod_class_s cls_q;
	logic slow_init_q;
	logic [15:0] tmo_max_q;
	logic [2:0] cnt_q;
	logic [7:0] b0_q;
	logic [7:0] src_q;
	logic pos_q;
	logic idx_q;
	logic tmr_load_q;
	logic [TMR_W-1:0] tmr_us_q;
	logic expired;
	logic apb_acc;
	logic [2:0] pay;
	logic is_pos;
	logic is_neg;
	kod_class_s cls_now;

	// access phase handshake: one wait state, answer registered
	assign apb_acc = psel_i & penable_i & ~pready_o;

	// timeout counter shared by the fast response, key byte and 5 baud response waits
	kod_us_timer u_tmr (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.load_i(tmr_load_q),
		.us_i(tmr_us_q),
		.expired_o(expired)
	);

	// apb answer and read data
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= apb_acc;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			if (apb_acc) begin
				case (paddr_i)
					REG_CTRL: prdata_o <= {29'h0, ctrl_q};
					REG_STAT: prdata_o <= {16'h0, state_q[9:8] == 2'b0 ?
						1'b0 : 1'b1, 3'h0, state_q[9], state_q[8],
						slow_init_q, ~state_q[0], tmo_max_q[15:8] == 8'h0 ?
						8'h00 : 8'h01};
					REG_KEYS: prdata_o <= {cls_q.fmt, 4'h0, cls_q.hdr,
						cls_q.proto, keys_q};
					REG_RESP: prdata_o <= {cls_q.gap_ms, src_q, tmo_max_q};
					REG_TAG: prdata_o <= {16'h0, tag_q};
					default: pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// software control: option bits and start pulse
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= CTRL_RST;
			start_q <= 1'b0;
			tag_q <= UNDEF_TAG;
		end else begin
			start_q <= 1'b0;
			if (apb_acc && pwrite_i) begin
				if (paddr_i == REG_CTRL) begin
					ctrl_q <= {pwdata_i[CTRL_TAGV], pwdata_i[CTRL_XHDR],
						1'b0};
					start_q <= pwdata_i[CTRL_START];
				end
				if (paddr_i == REG_TAG)
					tag_q <= pwdata_i[15:0];
			end
		end
	end

	// response payload position and pattern checks
	assign pay = cnt_q - HDR_LEN;
	assign is_pos = slow_init_q ? kod_match2(b0_q, rx_byte_i,
		RSP_PIDS_POS, PID_ZERO) : (b0_q == RSP_START_POS);
	assign is_neg = slow_init_q ? kod_match2(b0_q, rx_byte_i, RSP_NEG,
		SVC_PIDS) : kod_match2(b0_q, rx_byte_i, RSP_NEG,
		SVC_START);
	assign cls_now = kod_classify('{hi: rx_byte_i, lo: keys_q.lo});

	// detection sequence
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			tx_slow_o <= 1'b0;
			tx_wake_o <= 1'b0;
			slow_init_q <= 1'b0;
			tmo_max_q <= 16'h0000;
			tmr_load_q <= 1'b0;
			tmr_us_q <= '0;
			keys_q <= '0;
			cls_q <= '{PROTO_NONE, HF_NONE, 8'h00, 8'h00};
			idx_q <= 1'b0;
			pos_q <= 1'b0;
		end else begin
			tmr_load_q <= 1'b0;
			case (state_q)
				ST_IDLE, ST_DONE, ST_FAIL: begin
					if (start_q) begin
						state_q <= ST_F_WAKE;
						slow_init_q <= 1'b0;
						tmo_max_q <= 16'(FAST_TMO_US);
						cls_q <= '{PROTO_NONE, HF_NONE, 8'h00, 8'h00};
						keys_q <= '0;
						pos_q <= 1'b0;
						tx_wake_o <= 1'b1;
					end
				end
				ST_F_WAKE: begin
					if (tx_done_i) begin
						tx_wake_o <= 1'b0;
						tx_valid_o <= 1'b1;
						tx_byte_o <= SVC_START;
						state_q <= ST_F_SEND;
					end
				end
				ST_F_SEND: begin
					if (tx_done_i) begin
						tx_valid_o <= 1'b0;
						tmr_load_q <= 1'b1;
						tmr_us_q <= TMR_W'(FAST_TMO);
						state_q <= ST_F_RESP;
					end
				end
				ST_F_RESP: begin
					if (rx_valid_i && pay == 3'h1 && is_pos) begin
						pos_q <= 1'b1;
						cls_q <= '{PROTO_14230, HF_NONE, FMT_14230,
							8'(MIN_GAP_FAST_MS)};
					end
					if (expired && !tmr_load_q) begin
						if (pos_q) begin
							state_q <= ST_DONE;
						end else begin
							// fast init gave no positive answer: fall back
							state_q <= ST_S_ADDR;
							slow_init_q <= 1'b1;
							tmo_max_q <= 16'(SLOW_TMO_US);
							tx_valid_o <= 1'b1;
							tx_slow_o <= 1'b1;
							tx_byte_o <= ADDR_FUNC;
						end
					end
				end
				ST_S_ADDR: begin
					if (tx_done_i) begin
						tx_valid_o <= 1'b0;
						tx_slow_o <= 1'b0;
						tmr_load_q <= 1'b1;
						tmr_us_q <= TMR_W'(KEY_TMO);
						idx_q <= 1'b0;
						state_q <= ST_S_KEYS;
					end
				end
				ST_S_KEYS: begin
					// sync byte, then low key byte, then high key byte
					if (rx_valid_i) begin
						if (idx_q == 1'b0 && cnt_q == 3'h1) begin
							keys_q.lo <= rx_byte_i;
							idx_q <= 1'b1;
						end else if (idx_q) begin
							keys_q.hi <= rx_byte_i;
							cls_q <= cls_now;
							if (cls_now.proto == PROTO_NONE) begin
								state_q <= ST_FAIL;
							end else begin
								tx_valid_o <= 1'b1;
								tx_byte_o <= SVC_PIDS;
								idx_q <= 1'b0;
								state_q <= ST_S_REQ;
							end
						end
					end else if (expired && !tmr_load_q) begin
						state_q <= ST_FAIL;
					end
				end
				ST_S_REQ: begin
					if (tx_done_i) begin
						if (!idx_q) begin
							tx_byte_o <= PID_ZERO;
							idx_q <= 1'b1;
						end else begin
							tx_valid_o <= 1'b0;
							tmr_load_q <= 1'b1;
							tmr_us_q <= TMR_W'(WIN_TMO);
							state_q <= ST_S_RESP;
						end
					end
				end
				ST_S_RESP: begin
					if (rx_valid_i && pay == 3'h1 && is_pos)
						pos_q <= 1'b1;
					if (expired && !tmr_load_q)
						state_q <= pos_q ? ST_DONE : ST_FAIL;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// header capture and per response reporting
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 3'h0;
			b0_q <= 8'h00;
			src_q <= SRC_INVALID;
			resp_valid_o <= 1'b0;
			resp_src_o <= SRC_INVALID;
			resp_tag_o <= UNDEF_TAG;
		end else begin
			resp_valid_o <= 1'b0;
			if (rx_valid_i) begin
				cnt_q <= rx_eom_i ? 3'h0 :
					(cnt_q == 3'h7 ? cnt_q : cnt_q + 3'h1);
				if (pay == 3'h0)
					b0_q <= rx_byte_i;
				if (cnt_q == 3'h2 && ctrl_q[CTRL_XHDR])
					src_q <= rx_byte_i;
				if ((state_q == ST_F_RESP || state_q == ST_S_RESP) &&
						pay == 3'h1 && (is_pos || is_neg)) begin
					resp_valid_o <= 1'b1;
					resp_src_o <= ctrl_q[CTRL_XHDR] ? src_q :
						SRC_INVALID;
					resp_tag_o <= ctrl_q[CTRL_TAGV] ? tag_q :
						UNDEF_TAG;
				end
			end
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	sequence fast_sent_s;
		state_q == ST_F_SEND && tx_done_i;
	endsequence
	sequence wait_load_s;
		tmr_load_q && tmr_us_q == TMR_W'(FAST_TMO);
	endsequence

	fast_first_a: assert property ($rose(tx_wake_o) |-> state_q == ST_F_WAKE
		&& !slow_init_q) else $error("wake not first");
	fast_byte_a: assert property (state_q == ST_F_SEND && tx_valid_o
		|-> tx_byte_o == 8'h81) else $error("bad start byte");
	fast_timer_a: assert property (fast_sent_s |=> wait_load_s)
		else $error("fast wait not loaded");
	tmo_val_a: assert property (state_q == ST_S_KEYS |-> tmo_max_q == 16'h0)
		else $error("5 baud timeout not zero");
	addr_byte_a: assert property ($rose(tx_slow_o) |-> tx_byte_o == 8'h33)
		else $error("bad 5 baud address");
	class_fmt_a: assert property (state_q == ST_S_REQ |-> (cls_q.proto ==
		PROTO_9141 && cls_q.fmt == 8'h48) || (cls_q.proto == PROTO_14230
		&& cls_q.fmt == 8'h80)) else $error("format byte");
	key_bad_a: assert property (state_q == ST_S_KEYS && rx_valid_i && idx_q
		&& cls_now.proto == PROTO_NONE |=> state_q == ST_FAIL)
		else $error("unknown keys accepted");
	tag_undef_a: assert property (resp_valid_o && !$past(ctrl_q[CTRL_TAGV])
		|-> resp_tag_o == 16'hffff) else $error("tag before table");
	pid_req_a: assert property (state_q == ST_S_REQ && idx_q && tx_valid_o
		|-> tx_byte_o == 8'h00) else $error("bad pid byte");
	neg_flag_a: assert property (state_q == ST_F_RESP && rx_valid_i &&
		pay == 3'h1 && b0_q == 8'h7f && rx_byte_i == 8'h81 |=>
		!$rose(pos_q)) else $error("negative taken as positive");

endmodule

/* kod_ecu_model.sv */
// Purpose: behavioural model of the control units on the k-line
// Assumes: byte link handshake of the detector, one item at a time
// Notes: gaps are clock cycles, scaled far below road timing
module kod_ecu_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// byte link from the detector
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_slow_i,
	input wire logic tx_wake_i,
	output logic tx_done_o,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_eom_o,
	// scenario chosen by the bench
	input wire logic [1:0] fast_kind_i,
	input wire logic [1:0] slow_kind_i,
	input wire logic [15:0] keys_i,
	input wire logic [7:0] src_i,
	input wire logic [7:0] dly_i,
	input wire logic [7:0] gap_i,
	output int bad_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int step;

	// item expected after the wake pattern, in order
	function automatic logic [8:0] exp_item(input int s);
		case (s)
			1: return {1'b0, 8'h81};
			2: return {1'b1, 8'h33};
			3: return {1'b0, 8'h01};
			4: return {1'b0, 8'h00};
			default: return 9'h1ff;
		endcase
	endfunction

	// sends a message msb byte first, eom on the last
	task automatic send(input logic [39:0] m, input int n);
		for (int k = n - 1; k >= 0; k--) begin
			rx_valid_o <= 1'b1;
			rx_byte_o <= m[8*k +: 8];
			rx_eom_o <= (k == 0);
			@(posedge mclk_i);
			rx_valid_o <= 1'b0;
			rx_byte_o <= ~m[8*k +: 8]; // idle line never keeps the last byte
			rx_eom_o <= 1'b0;
			@(posedge mclk_i);
		end
	endtask

	// accept each item, then answer as the scenario says
	initial begin
		logic [9:0] item;
		tx_done_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h5a;
		rx_eom_o = 1'b0;
		step = 0;
		bad_o = 0;
		forever begin
			@(posedge mclk_i);
			if (rst_b_i && (tx_valid_i || tx_wake_i)) begin
				item = {tx_wake_i, tx_slow_i, tx_byte_i};
				repeat (dly_i) @(posedge mclk_i);
				tx_done_o <= 1'b1;
				@(posedge mclk_i);
				tx_done_o <= 1'b0;
				if (item[9]) begin
					step = 1;
				end else begin
					if (item[8:0] !== exp_item(step)) bad_o++;
					step++;
					repeat (gap_i) @(posedge mclk_i);
					if (step == 2 && fast_kind_i == 2'h1)
						send({16'h80f1, src_i, 16'hc18f}, 5);
					if (step == 2 && fast_kind_i == 2'h2)
						send({16'h80f1, src_i, 16'h7f81}, 5);
					if (step == 3)
						send({16'h0, 8'h55, keys_i[7:0], keys_i[15:8]}, 3);
					if (step == 5 && keys_i[7:0] == 8'h08)
						repeat (100) @(posedge mclk_i);
					if (step == 5 && slow_kind_i == 2'h1)
						send({16'h486b, src_i, 16'h4100}, 5);
					if (step == 5 && slow_kind_i == 2'h2)
						send({16'h486b, src_i, 16'h7f01}, 5);
				end
			end
		end
	end
endmodule

/* kod_pkg.sv */
// Purpose: shared constants, types and decode functions for the
//          k-line protocol detector
// Assumes: 25 MHz clock, apb register access
// Notes: times are kept in their own unit and the cycles per microsecond set here
package kod_pkg;

	// clock and time base
	localparam int CLK_NS = 40;
	localparam int CYC_PER_US = 1000 / CLK_NS;
	localparam int FAST_TMO_US = 25000; // response timeout, fast init
	localparam int SLOW_TMO_US = 0; // response timeout, 5 baud init
	localparam int P2_WIN_US = 50000; // accepted request-to-response window
	localparam int KEY_WAIT_US = 400000; // wait for sync and key bytes
	localparam int MIN_GAP_9141_MS = 25;
	localparam int MIN_GAP_FAST_MS = 0;
	localparam int TMR_W = 20;

	// service and pattern bytes
	localparam logic [7:0] SVC_START = 8'h81;
	localparam logic [7:0] RSP_START_POS = 8'hc1;
	localparam logic [7:0] RSP_NEG = 8'h7f;
	localparam logic [7:0] SVC_PIDS = 8'h01;
	localparam logic [7:0] PID_ZERO = 8'h00;
	localparam logic [7:0] RSP_PIDS_POS = 8'h41;
	localparam logic [7:0] ADDR_FUNC = 8'h33;

	// key bytes and response format bytes
	localparam logic [7:0] KB_HI_14230 = 8'h8f;
	localparam logic [7:0] KB_LO_E9 = 8'he9;
	localparam logic [7:0] KB_LO_6B = 8'h6b;
	localparam logic [7:0] KB_LO_6D = 8'h6d;
	localparam logic [7:0] KB_LO_EF = 8'hef;
	localparam logic [7:0] KB_9141_SLOW = 8'h08;
	localparam logic [7:0] KB_9141_FAST = 8'h94;
	localparam logic [7:0] FMT_9141 = 8'h48;
	localparam logic [7:0] FMT_14230 = 8'h80;
	localparam logic [15:0] UNDEF_TAG = 16'hffff; // arbitrary value
	localparam logic [7:0] SRC_INVALID = 8'hff;
	localparam logic [2:0] HDR_LEN = 3'h3;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_KEYS = 8'h08;
	localparam logic [7:0] REG_RESP = 8'h0c;
	localparam logic [7:0] REG_TAG = 8'h10;
	localparam int CTRL_START = 0;
	localparam int CTRL_XHDR = 1;
	localparam int CTRL_TAGV = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	typedef enum logic [1:0] {
		PROTO_NONE = 2'h0,
		PROTO_9141 = 2'h1,
		PROTO_14230 = 2'h2
	} kod_proto_e;

	typedef enum logic [1:0] {
		HF_NONE = 2'h0,
		HF_3B = 2'h1,
		HF_1OR3 = 2'h2,
		HF_1OR3_LEN = 2'h3
	} kod_hdrfmt_e;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} kod_keys_s;

	typedef struct packed {
		kod_proto_e proto;
		kod_hdrfmt_e hdr;
		logic [7:0] fmt;
		logic [7:0] gap_ms;
	} kod_class_s;

	// classify a key byte pair
	function automatic kod_class_s kod_classify(input kod_keys_s k);
		kod_class_s c;
		c = '{PROTO_NONE, HF_NONE, 8'h00, 8'h00};
		if (k.hi == KB_HI_14230) begin
			c.proto = PROTO_14230;
			c.fmt = FMT_14230;
			c.gap_ms = 8'(MIN_GAP_FAST_MS);
			case (k.lo)
				KB_LO_E9, KB_LO_6B: c.hdr = HF_3B;
				KB_LO_6D: c.hdr = HF_1OR3;
				KB_LO_EF: c.hdr = HF_1OR3_LEN;
				default: c = '{PROTO_NONE, HF_NONE, 8'h00, 8'h00};
			endcase
		end else if (k.hi == k.lo &&
				(k.lo == KB_9141_SLOW || k.lo == KB_9141_FAST)) begin
			c.proto = PROTO_9141;
			c.hdr = HF_3B;
			c.fmt = FMT_9141;
			c.gap_ms = (k.lo == KB_9141_SLOW) ? 8'(MIN_GAP_9141_MS) :
				8'(MIN_GAP_FAST_MS);
		end
		return c;
	endfunction

	// two-byte pattern match
	function automatic logic kod_match2(input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] ea,
			input logic [7:0] eb);
		return (a == ea) && (b == eb);
	endfunction

endpackage

/* kod_us_timer.sv */
// Purpose: microsecond timeout counter
// Assumes: load pulse starts a fresh count
// Notes: a load of zero expires on the next edge
module kod_us_timer
	import kod_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// control
	input wire logic load_i,
	input wire logic [TMR_W-1:0] us_i,
	// status
	output logic expired_o
);

	logic [4:0] pre_q;
	logic [TMR_W-1:0] us_q;
	logic run_q;

	// prescaler to one microsecond ticks and the down counter
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_q <= 5'h0;
			us_q <= '0;
			run_q <= 1'b0;
			expired_o <= 1'b0;
		end else if (load_i) begin
			pre_q <= 5'h0;
			us_q <= us_i;
			run_q <= 1'b1;
			expired_o <= 1'b0;
		end else if (run_q) begin
			if (us_q == '0) begin
				run_q <= 1'b0;
				expired_o <= 1'b1;
			end else if (pre_q == 5'(CYC_PER_US - 1)) begin
				pre_q <= 5'h0;
				us_q <= us_q - 1'b1;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
		end
	end

endmodule

/* test_kod_detect.sv */
// Purpose: self-checking bench for the k-line protocol detector
// Assumes: timeouts shortened to a few tens of microseconds
// Notes: each case runs fast init, then 5 baud init on fallback
module test_kod_detect;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FT = 20;
	localparam int WT = 40;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, txv, txs, txw, txd, rxv, rxe, rspv;
	logic [7:0] txb, rxb, rsps, src, dly, gap;
	logic [15:0] rspt, keys, tag;
	logic [1:0] fk, sk;
	logic xhdr, tagv;
	int n_mismatch = 0, tests_run = 0, n_resp = 0, bad;

	kod_detect #(.FAST_TMO(FT), .WIN_TMO(WT), .KEY_TMO(WT)) kod_detect_i (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .tx_valid_o(txv), .tx_byte_o(txb),
		.tx_slow_o(txs), .tx_wake_o(txw), .tx_done_i(txd),
		.rx_valid_i(rxv), .rx_byte_i(rxb), .rx_eom_i(rxe),
		.resp_valid_o(rspv), .resp_src_o(rsps), .resp_tag_o(rspt));

	kod_ecu_model kod_ecu_model_i (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tx_valid_i(txv),
		.tx_byte_i(txb), .tx_slow_i(txs), .tx_wake_i(txw),
		.tx_done_o(txd), .rx_valid_o(rxv), .rx_byte_o(rxb),
		.rx_eom_o(rxe), .fast_kind_i(fk), .slow_kind_i(sk),
		.keys_i(keys), .src_i(src), .dly_i(dly), .gap_i(gap),
		.bad_o(bad));

	// clock
	always #20 mclk_i = ~mclk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// format byte, header format and protocol from key bytes
	function automatic logic [11:0] exp_keys(input logic [15:0] k);
		if (k[15:8] == 8'h8f && k[7:0] inside {8'he9, 8'h6b})
			return 12'h806;
		if (k == 16'h8f6d) return 12'h80a;
		if (k == 16'h8fef) return 12'h80e;
		if (k == 16'h0808 || k == 16'h9494) return 12'h485;
		return 12'h000;
	endfunction

	// every answer carries its source and tag when the option bits are set, 0xff and 0xffff when they are clear
	always @(posedge mclk_i) begin
		if (rspv === 1'b1) begin
			n_resp++;
			chk(32'(rsps), xhdr ? 32'(src) : 32'hff);
			chk(32'(rspt), tagv ? 32'(tag) : 32'hffff);
		end
	end

	// watchdog
	initial begin
		#(90000 * 40);
		n_mismatch++;
		wrap_up();
	end

	// main sequence
	initial begin
		logic [31:0] rd;
		logic er, ok, valid, fast;
		logic [15:0] kt [6];
		logic [7:0] h;
		int n;
		kt = '{16'h0808, 16'h9494, 16'h8fe9, 16'h8f6b, 16'h8f6d, 16'h8fef};
		{fk, sk, keys, src, dly, gap, tag, xhdr, tagv} = '0;
		void'($urandom(32'h02048135));
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		chk({rspt, rsps}, 32'h00ff_ffff);
		apb(1'b0, 8'h40, 32'h0, rd, er);
		chk({rd[30:0], er}, 32'h0000_0001);
		for (int i = 0; i < 10; i++) begin
			h = 8'($urandom) & 8'h7f;
			keys = (i < 9) ? kt[i % 6] : {h, h ^ 8'h01};
			fk = (i == 6) ? 2'h1 : 2'(($urandom % 2) * 2);
			sk = (i == 7) ? 2'h0 : (i == 8) ? 2'h2 : 2'h1;
			{src, tag, xhdr, tagv} = 26'($urandom);
			dly = 8'($urandom % 20);
			gap = 8'($urandom % 200);
			n_resp = 0;
			apb(1'b1, 8'h10, {16'h0, tag}, rd, er);
			apb(1'b1, 8'h00, {29'h0, tagv, xhdr, 1'b1}, rd, er);
			apb(1'b0, 8'h00, 32'h0, rd, er);
			chk(rd, {29'h0, tagv, xhdr, 1'b0});
			n = 0;
			do begin
				apb(1'b0, 8'h04, 32'h0, rd, er);
				n++;
			end while (rd[15] !== 1'b1 && n < 3000);
			valid = (i < 9);
			fast = (fk == 2'h1);
			ok = (fk == 2'h1) || (valid && sk == 2'h1);
			// busy stays set in done and fail; timeout byte flags >= 256 us
			chk(rd, 32'({4'h8, !ok, ok, !fast, 8'h80, fast}));
			apb(1'b0, 8'h0c, 32'h0, rd, er);
			// reported maximum is the nominal value, not the shortened timer
			chk(32'(rd[15:0]), fast ? kod_pkg::FAST_TMO_US : 0);
			if (fk != 2'h1 && ok) begin
				chk(32'(rd[31:24]), (keys[7:0] == 8'h08) ? 25 : 0);
				apb(1'b0, 8'h08, 32'h0, rd, er);
				chk({rd[31:24], rd[19:16], rd[15:0]}, {exp_keys(keys), keys});
			end
			chk(n_resp, (fk != 2'h0) + (fk != 2'h1 && valid && sk != 2'h0));
		end
		chk(bad, 0);
		wrap_up();
	end
endmodule
